// File: refsel_pkg.sv
// shared types and constants for reference selection and failover
`default_nettype none
package refsel_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int EVT_W = 4;
    localparam int EVT_IN0_FAULT = 0;
    localparam int EVT_IN1_FAULT = 1;
    localparam int EVT_SWITCH = 2;
    localparam int EVT_INIT = 3;
    localparam logic [EVT_W-1:0] MASK_RST = 4'h0;
    localparam logic [EVT_W-1:0] STATUS_RST = 4'h0;
    localparam int CTL_W = 5;
    localparam int CTL_FB = 0;
    localparam int CTL_INIT = 1;
    localparam int CTL_SEL = 2;
    localparam int CTL_HOLD = 3;
    localparam int CTL_DRST = 4;
    // init strobe and divider reset idle high
    localparam logic [CTL_W-1:0] CTL_RST = 5'h12;
    localparam logic [1:0] FB_EDGES_FAULT = 2'h2;
    localparam logic RST_ACTIVE = 1'b0;
    localparam logic RST_PRIMARY = 1'b0;

    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_ON_PRIMARY,
        MODE_ON_SECONDARY
    } mode_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [1:0] cnt;
        logic fault;
    } mon_state_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;

    typedef struct packed {
        logic [CTL_W-1:0] sync1;
        logic [CTL_W-1:0] sync2;
        logic init_prev;
        logic fb_prev;
        logic ref_prev;
        mode_t mode;
        logic primary;
        logic active;
        logic [1:0] flag;
        logic out_true;
        logic out_comp;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic irq;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [7:0] wbyte;
        logic wstrb0;
        axi_rsp_t rsp;
    } core_state_t;
endpackage
`default_nettype wire

// File: ref_activity_monitor.sv
// stuck-high or stuck-low watch for one reference input
`default_nettype none
module ref_activity_monitor (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ref_i,
    input wire logic fb_rise_i,
    input wire logic clear_i,
    output logic level_o,
    output logic fault_o
);
    refsel_pkg::mon_state_t q;
    refsel_pkg::mon_state_t next_q;
    logic edge_seen;

    always_comb begin
        next_q = q;
        next_q.s1 = ref_i;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        edge_seen = q.s2 ^ q.s3;
        if (edge_seen || clear_i) begin
            next_q.cnt = 2'h0;
            next_q.fault = 1'b0;
        // two feedback rises span a period
        end else if (fb_rise_i && !q.fault) begin
            next_q.cnt = q.cnt + 2'h1;
            if (next_q.cnt == refsel_pkg::FB_EDGES_FAULT) begin
                next_q.fault = 1'b1;
            end
        end
        if (reset_i) begin
            next_q = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= next_q;
    end

    assign level_o = q.s3;
    assign fault_o = q.fault;

    a_stuck_sets_fault: assert property (@(posedge clk_i) disable iff (reset_i)
        (fb_rise_i && !edge_seen && !clear_i && q.cnt == 2'h1) |=> fault_o)
        else $error("stuck input not flagged");
    a_edge_clears_fault: assert property (@(posedge clk_i) disable iff (reset_i)
        edge_seen |=> !fault_o)
        else $error("toggling input still flagged");
endmodule // ref_activity_monitor
`default_nettype wire

// File: redundant_ref_clock_failover.sv
// reference selection, failover, divider reset and register slave
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
// How it works
// - init strobe fall adopts select pin input
// - init event clears both fault flags
// - stuck one feedback period means failed
// - failure raises that input's own flag
// - flags track live input state continuously
// - manual hold forces select pin input
// - manual select change moves reference, indicator
// - hold low enables automatic failover
// - failed initial swaps to good secondary
// - indicator updated after automatic switch
// - recovered initial marked good, no swap
// - failed secondary returns to good initial
// - divider reset low: true low, comp high
// - divider reset high runs outputs normally
// - indicator low input 0, high input 1
// - select high picks input 1, else 0
module redundant_ref_clock_failover (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ref_in0_i,
    input wire logic ref_in1_i,
    input wire logic fb_clk_i,
    input wire logic init_strobe_n_i,
    input wire logic ref_select_i,
    input wire logic manual_hold_i,
    input wire logic divider_reset_n_i,
    input wire refsel_pkg::axi_req_t axi_req_i,
    output var refsel_pkg::axi_rsp_t axi_rsp_o,
    output logic active_ref_flag_o,
    output logic in0_fault_flag_o,
    output logic in1_fault_flag_o,
    output logic out_true_o,
    output logic out_comp_o,
    output logic irq_o
);
    refsel_pkg::core_state_t q;
    refsel_pkg::core_state_t next_q;
    logic [1:0] ref_pins;
    logic [1:0] mon_level;
    logic [1:0] mon_fault;
    logic init_evt;
    logic fb_rise;
    logic sel;
    logic hold;
    logic auto_failover;
    logic drst_n;
    logic sel_level;
    logic ref_rise;
    logic [refsel_pkg::EVT_W-1:0] events;
    logic [refsel_pkg::EVT_W-1:0] w1c;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_write;
    logic wr_ok;

    assign ref_pins = {ref_in1_i, ref_in0_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_mon
            ref_activity_monitor u_mon (
                .clk_i(clk_i),
                .reset_i(reset_i),
                .ref_i(ref_pins[gi]),
                .fb_rise_i(fb_rise),
                .clear_i(init_evt),
                .level_o(mon_level[gi]),
                .fault_o(mon_fault[gi])
            );
        end
    endgenerate

    // synced pin levels; pulls are resolved on the board side
    assign sel = q.sync2[refsel_pkg::CTL_SEL];
    assign hold = q.sync2[refsel_pkg::CTL_HOLD];
    assign drst_n = q.sync2[refsel_pkg::CTL_DRST];
    assign auto_failover = ~hold;
    assign init_evt = q.init_prev & ~q.sync2[refsel_pkg::CTL_INIT];
    // feedback must be well below clk_i for this edge to be seen
    assign fb_rise = q.sync2[refsel_pkg::CTL_FB] & ~q.fb_prev;
    assign sel_level = mon_level[q.active];
    assign ref_rise = sel_level & ~q.ref_prev;

    assign aw_hs = axi_req_i.awvalid & q.rsp.awready;
    assign w_hs = axi_req_i.wvalid & q.rsp.wready;
    assign ar_hs = axi_req_i.arvalid & q.rsp.arready;
    assign do_write = q.aw_got & q.w_got & ~q.rsp.bvalid;
    assign wr_ok = (q.awaddr == refsel_pkg::ADDR_STATUS)
        || (q.awaddr == refsel_pkg::ADDR_MASK);

    always_comb begin
        next_q = q;
        events = '0;
        w1c = '0;
        next_q.sync1 = {divider_reset_n_i, manual_hold_i, ref_select_i,
            init_strobe_n_i, fb_clk_i};
        next_q.sync2 = q.sync1;
        next_q.init_prev = q.sync2[refsel_pkg::CTL_INIT];
        next_q.fb_prev = q.sync2[refsel_pkg::CTL_FB];
        next_q.ref_prev = sel_level;

        // init clears flags, else per-input flag
        if (init_evt) begin
            next_q.flag = 2'h0;
        end else begin
            next_q.flag = mon_fault;
        end

        if (init_evt) begin
            // adopt select pin as initial, high is input 1
            next_q.primary = sel;
            next_q.active = sel;
            next_q.mode = hold ? refsel_pkg::MODE_MANUAL : refsel_pkg::MODE_ON_PRIMARY;
        end else if (hold) begin
            // select pin wins even if flagged, follow its changes
            next_q.mode = refsel_pkg::MODE_MANUAL;
            next_q.active = sel;
        end else begin
            case (q.mode)
                refsel_pkg::MODE_MANUAL: begin
                    // leaving hold resumes failover from current input
                    if (q.active == q.primary) begin
                        next_q.mode = refsel_pkg::MODE_ON_PRIMARY;
                    end else begin
                        next_q.mode = refsel_pkg::MODE_ON_SECONDARY;
                    end
                end
                refsel_pkg::MODE_ON_PRIMARY: begin
                    // swap only to a good secondary, else hold
                    if (q.flag[q.primary] && !q.flag[~q.primary]) begin
                        next_q.active = ~q.primary;
                        next_q.mode = refsel_pkg::MODE_ON_SECONDARY;
                    end
                end
                refsel_pkg::MODE_ON_SECONDARY: begin
                    // return when secondary fails and initial good
                    if (q.flag[~q.primary] && !q.flag[q.primary]) begin
                        next_q.active = q.primary;
                        next_q.mode = refsel_pkg::MODE_ON_PRIMARY;
                    end
                end
                default: begin
                    next_q.mode = refsel_pkg::MODE_MANUAL;
                end
            endcase
        end

        // dividers held, else toggle on reference
        if (!drst_n) begin
            next_q.out_true = 1'b0;
            next_q.out_comp = 1'b1;
        end else if (ref_rise) begin
            next_q.out_true = ~q.out_true;
            next_q.out_comp = q.out_true;
        end

        events[refsel_pkg::EVT_IN0_FAULT] = next_q.flag[0] & ~q.flag[0];
        events[refsel_pkg::EVT_IN1_FAULT] = next_q.flag[1] & ~q.flag[1];
        events[refsel_pkg::EVT_SWITCH] = next_q.active ^ q.active;
        events[refsel_pkg::EVT_INIT] = init_evt;

        // write address and data may arrive in either order
        if (aw_hs) begin
            next_q.aw_got = 1'b1;
            next_q.awaddr = axi_req_i.awaddr;
        end
        if (w_hs) begin
            next_q.w_got = 1'b1;
            next_q.wbyte = axi_req_i.wdata[7:0];
            next_q.wstrb0 = axi_req_i.wstrb[0];
        end
        if (q.rsp.bvalid && axi_req_i.bready) begin
            next_q.rsp.bvalid = 1'b0;
        end
        if (do_write) begin
            next_q.aw_got = 1'b0;
            next_q.w_got = 1'b0;
            next_q.rsp.bvalid = 1'b1;
            next_q.rsp.bresp = wr_ok ? refsel_pkg::RESP_OKAY : refsel_pkg::RESP_SLVERR;
            if (q.wstrb0 && q.awaddr == refsel_pkg::ADDR_STATUS) begin
                w1c = q.wbyte[refsel_pkg::EVT_W-1:0];
            end
            if (q.wstrb0 && q.awaddr == refsel_pkg::ADDR_MASK) begin
                next_q.mask = q.wbyte[refsel_pkg::EVT_W-1:0];
            end
        end
        // an event in the clearing cycle survives
        next_q.status = (q.status & ~w1c) | events;
        next_q.irq = |(next_q.status & next_q.mask);

        if (q.rsp.rvalid && axi_req_i.rready) begin
            next_q.rsp.rvalid = 1'b0;
        end
        if (ar_hs) begin
            next_q.rsp.rvalid = 1'b1;
            next_q.rsp.rdata = 32'h0000_0000;
            next_q.rsp.rresp = refsel_pkg::RESP_OKAY;
            case (axi_req_i.araddr)
                refsel_pkg::ADDR_STATUS: begin
                    next_q.rsp.rdata[refsel_pkg::EVT_W-1:0] = q.status;
                end
                refsel_pkg::ADDR_MASK: begin
                    next_q.rsp.rdata[refsel_pkg::EVT_W-1:0] = q.mask;
                end
                refsel_pkg::ADDR_STATE: begin
                    next_q.rsp.rdata[7:0] = {drst_n, q.mode, hold, q.flag,
                        q.primary, q.active};
                end
                default: begin
                    next_q.rsp.rresp = refsel_pkg::RESP_SLVERR;
                end
            endcase
        end
        // one write and one read in flight at a time
        next_q.rsp.awready = ~next_q.aw_got & ~next_q.rsp.bvalid;
        next_q.rsp.wready = ~next_q.w_got & ~next_q.rsp.bvalid;
        next_q.rsp.arready = ~next_q.rsp.rvalid;

        if (reset_i) begin
            next_q = '0;
            next_q.sync1 = refsel_pkg::CTL_RST;
            next_q.sync2 = refsel_pkg::CTL_RST;
            next_q.init_prev = 1'b1;
            next_q.primary = refsel_pkg::RST_PRIMARY;
            next_q.active = refsel_pkg::RST_ACTIVE;
            next_q.mode = refsel_pkg::MODE_MANUAL;
            next_q.out_comp = 1'b1;
            next_q.status = refsel_pkg::STATUS_RST;
            next_q.mask = refsel_pkg::MASK_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= next_q;
    end

    assign axi_rsp_o = q.rsp;
    assign active_ref_flag_o = q.active;
    assign in0_fault_flag_o = q.flag[0];
    assign in1_fault_flag_o = q.flag[1];
    assign out_true_o = q.out_true;
    assign out_comp_o = q.out_comp;
    assign irq_o = q.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_init_adopts_sel: assert property (
        init_evt |=> (q.active == $past(sel) && q.primary == $past(sel)))
        else $error("init did not adopt select level");
    a_indicator_after_init: assert property (
        init_evt |=> active_ref_flag_o == $past(sel))
        else $error("indicator differs from select after init");
    a_init_clears_flags: assert property (
        init_evt |=> (!in0_fault_flag_o && !in1_fault_flag_o))
        else $error("init left a fault flag set");
    a_flag_follows_mon: assert property (
        !init_evt |=> ({in1_fault_flag_o, in0_fault_flag_o} == $past(mon_fault)))
        else $error("fault flag not tracking its input");
    a_manual_uses_sel: assert property (
        hold |=> active_ref_flag_o == $past(sel))
        else $error("manual hold ignored select");
    a_auto_to_secondary: assert property (
        (auto_failover && !init_evt && q.mode == refsel_pkg::MODE_ON_PRIMARY
        && q.flag[q.primary] && !q.flag[~q.primary])
        |=> (q.active != q.primary && q.mode == refsel_pkg::MODE_ON_SECONDARY))
        else $error("no swap to good secondary");
    a_stay_on_secondary: assert property (
        (auto_failover && !init_evt && q.mode == refsel_pkg::MODE_ON_SECONDARY
        && !q.flag[~q.primary]) |=> $stable(q.active))
        else $error("left good secondary");
    a_back_to_initial: assert property (
        (auto_failover && !init_evt && q.mode == refsel_pkg::MODE_ON_SECONDARY
        && q.flag[~q.primary] && !q.flag[q.primary]) |=> q.active == q.primary)
        else $error("no return to good initial");
    a_both_bad_hold: assert property (
        (auto_failover && !init_evt && q.mode != refsel_pkg::MODE_MANUAL && &q.flag)
        |=> $stable(q.active))
        else $error("switched with both inputs failed");
    a_divider_reset: assert property (
        !drst_n |=> (!out_true_o && out_comp_o))
        else $error("outputs not static in divider reset");
    a_divider_runs: assert property (
        (drst_n && ref_rise) |=> (out_true_o != $past(out_true_o) && out_comp_o == !out_true_o))
        else $error("divider did not advance");
    a_irq_level: assert property (
        irq_o == |(q.status & q.mask))
        else $error("interrupt not matching status and mask");
    a_manual_follows_change: assert property (
        (hold && !init_evt && sel != q.active)
        |=> active_ref_flag_o != $past(active_ref_flag_o))
        else $error("manual select change not followed");
    a_hold_low_auto: assert property (
        (!hold && !init_evt && q.mode == refsel_pkg::MODE_MANUAL)
        |=> q.mode != refsel_pkg::MODE_MANUAL)
        else $error("failover not enabled with hold low");
    a_switch_reported: assert property (
        $changed(active_ref_flag_o) |-> q.status[refsel_pkg::EVT_SWITCH])
        else $error("reference change not reported");
    // unused read data bits stay zero
    a_rdata_upper_zero: assert property (
        axi_rsp_o.rvalid |-> ~|axi_rsp_o.rdata[31:8])
        else $error("read data above bit 7 not zero");
    a_outputs_complementary: assert property (
        out_comp_o == !out_true_o)
        else $error("output pair not complementary");

    c_auto_switch: cover property (
        q.mode == refsel_pkg::MODE_ON_PRIMARY ##1 q.mode == refsel_pkg::MODE_ON_SECONDARY);
    c_switch_back: cover property (
        q.mode == refsel_pkg::MODE_ON_SECONDARY ##1 q.mode == refsel_pkg::MODE_ON_PRIMARY);
    c_init_event: cover property (init_evt);
    c_manual_switch: cover property (hold && sel != q.active);
    c_reg_write: cover property (do_write && wr_ok);
endmodule // redundant_ref_clock_failover
`default_nettype wire

// File: refsel_board_model.sv
// board-side model: two reference clocks and the feedback clock
`default_nettype none
module refsel_board_model #(
    parameter int HALF0 = 4,
    parameter int HALF1 = 5,
    parameter int HALF_FB = 12
) (
    input wire logic clk_i,
    input wire logic stop0_i,
    input wire logic stop1_i,
    output logic ref_in0_o,
    output logic ref_in1_o,
    output logic fb_clk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int c0 = 0;
    int c1 = 0;
    int cf = 0;
    logic r0 = 1'b0;
    logic r1 = 1'b0;
    logic rf = 1'b0;
    assign ref_in0_o = r0;
    assign ref_in1_o = r1;
    assign fb_clk_o = rf;
    // both refs run from power-up
    // slow against clk_i so every level survives the synchronisers
    always @(posedge clk_i) begin
        c0 <= (c0 == HALF0 - 1) ? 0 : c0 + 1;
        c1 <= (c1 == HALF1 - 1) ? 0 : c1 + 1;
        cf <= (cf == HALF_FB - 1) ? 0 : cf + 1;
        // a stopped source freezes at whatever level it had, high or low
        if (c0 == HALF0 - 1 && !stop0_i) begin
            r0 <= ~r0;
        end
        if (c1 == HALF1 - 1 && !stop1_i) begin
            r1 <= ~r1;
        end
        if (cf == HALF_FB - 1) begin
            rf <= ~rf;
        end
    end
endmodule // refsel_board_model
`default_nettype wire

// File: redundant_ref_clock_failover_tb.sv
// testbench for reference selection, failover and register slave
`default_nettype none
`define CHECK(nm, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module redundant_ref_clock_failover_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, reset_i, ref0, ref1, fb, init_n, sel, hold, drst, stop0, stop1;
    logic active, flag0, flag1, otrue, ocomp, irq;
    refsel_pkg::axi_req_t req;
    refsel_pkg::axi_rsp_t rsp;
    int num_errors = 0;
    int num_checks = 0;

    refsel_board_model board (.clk_i(clk_i), .stop0_i(stop0), .stop1_i(stop1),
        .ref_in0_o(ref0), .ref_in1_o(ref1), .fb_clk_o(fb));
    redundant_ref_clock_failover uut (.clk_i(clk_i), .reset_i(reset_i),
        .ref_in0_i(ref0), .ref_in1_i(ref1), .fb_clk_i(fb), .init_strobe_n_i(init_n),
        .ref_select_i(sel), .manual_hold_i(hold), .divider_reset_n_i(drst),
        .axi_req_i(req), .axi_rsp_o(rsp), .active_ref_flag_o(active),
        .in0_fault_flag_o(flag0), .in1_fault_flag_o(flag1), .out_true_o(otrue),
        .out_comp_o(ocomp), .irq_o(irq));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tmo(input string s);
        $display("mismatch %s expected 1 seen 0", s);
        num_errors++;
        finish_test();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    function automatic logic obs(input int k);
        case (k)
            0: return active;
            1: return flag0;
            2: return flag1;
            3: return irq;
            default: return otrue;
        endcase
    endfunction

    // bounded wait on one observed output
    task automatic wait_obs(input int k, input logic v);
        int n;
        n = 0;
        while (obs(k) !== v && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        num_checks++;
        if (n == 300) begin
            tmo($sformatf("wait_%0d", k));
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk_i);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        while (!done && n < 50) begin
            @(posedge clk_i);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) begin
                done = 1'b1;
                req.bready <= 1'b0;
                `CHECK("bresp", er, rsp.bresp)
            end
        end
        if (!done) tmo("bvalid");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk_i);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        while (!done && n < 50) begin
            @(posedge clk_i);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) begin
                done = 1'b1;
                req.rready <= 1'b0;
                `CHECK("rresp", er, rsp.rresp)
                `CHECK("rdata", ed, rsp.rdata)
            end
        end
        if (!done) tmo("rvalid");
    endtask

    // falling init strobe, held low long enough for the synchroniser
    task automatic init_pulse();
        @(posedge clk_i);
        init_n <= 1'b0;
        cyc(6);
        init_n <= 1'b1;
        cyc(2);
    endtask

    task automatic done_t(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        req = '0;
        reset_i = 1'b1;
        init_n = 1'b1;
        drst = 1'b1;
        stop0 = 1'b0;
        stop1 = 1'b0;
        sel = 1'b1;
        hold = 1'b1;
        cyc(4);
        reset_i <= 1'b0;
        @(posedge clk_i);
        `CHECK("active", 1'b0, active)
        `CHECK("flag0", 1'b0, flag0)
        `CHECK("out_comp", 1'b1, ocomp)
        `CHECK("irq", 1'b0, irq)
        rd(refsel_pkg::ADDR_MASK, 32'h0000_0000, refsel_pkg::RESP_OKAY);
        rd(8'h0c, 32'h0000_0000, refsel_pkg::RESP_SLVERR);
        wr(8'h10, 32'h0000_00ff, refsel_pkg::RESP_SLVERR);
        done_t("reset_and_map");
        wait_obs(0, 1'b1);
        sel <= 1'b0;
        wait_obs(0, 1'b0);
        done_t("manual_select");
        hold <= 1'b0;
        cyc(4);
        sel <= 1'b1;
        cyc(10);
        `CHECK("active", 1'b0, active)
        init_pulse();
        `CHECK("active", 1'b1, active)
        `CHECK("flag1", 1'b0, flag1)
        rd(refsel_pkg::ADDR_STATE, 32'h0000_00a3, refsel_pkg::RESP_OKAY);
        done_t("init_auto");
        `CHECK("irq", 1'b0, irq)
        wr(refsel_pkg::ADDR_MASK, 32'h0000_0008, refsel_pkg::RESP_OKAY);
        wait_obs(3, 1'b1);
        rd(refsel_pkg::ADDR_MASK, 32'h0000_0008, refsel_pkg::RESP_OKAY);
        wr(refsel_pkg::ADDR_STATUS, 32'h0000_000f, refsel_pkg::RESP_OKAY);
        wait_obs(3, 1'b0);
        rd(refsel_pkg::ADDR_STATUS, 32'h0000_0000, refsel_pkg::RESP_OKAY);
        done_t("interrupt");
        @(posedge clk_i);
        stop1 <= 1'b1;
        cyc(12);
        `CHECK("flag1", 1'b0, flag1)
        wait_obs(2, 1'b1);
        `CHECK("flag0", 1'b0, flag0)
        wait_obs(0, 1'b0);
        stop1 <= 1'b0;
        wait_obs(2, 1'b0);
        cyc(40);
        `CHECK("active", 1'b0, active)
        stop0 <= 1'b1;
        wait_obs(1, 1'b1);
        wait_obs(0, 1'b1);
        stop1 <= 1'b1;
        wait_obs(2, 1'b1);
        cyc(30);
        `CHECK("active", 1'b1, active)
        stop0 <= 1'b0;
        stop1 <= 1'b0;
        wait_obs(1, 1'b0);
        wait_obs(2, 1'b0);
        done_t("failover");
        hold <= 1'b1;
        sel <= 1'b0;
        wait_obs(0, 1'b0);
        stop0 <= 1'b1;
        wait_obs(1, 1'b1);
        cyc(30);
        `CHECK("active", 1'b0, active)
        init_pulse();
        `CHECK("flag0", 1'b0, flag0)
        `CHECK("active", 1'b0, active)
        wait_obs(1, 1'b1);
        stop0 <= 1'b0;
        wait_obs(1, 1'b0);
        done_t("manual_hold_fault");
        drst <= 1'b0;
        cyc(4);
        repeat (16) begin
            @(posedge clk_i);
            `CHECK("out_true", 1'b0, otrue)
            `CHECK("out_comp", 1'b1, ocomp)
        end
        drst <= 1'b1;
        wait_obs(4, 1'b1);
        wait_obs(4, 1'b0);
        `CHECK("out_comp", 1'b1, ocomp)
        done_t("divider_reset");
        cyc(5);
        finish_test();
    end
endmodule // redundant_ref_clock_failover_tb
`undef CHECK
`default_nettype wire
